// [hw/bidir_clocked_fifo_mailbox.sv]
// Bidirectional queue pair with mailboxes, port B width matching, swapping and parity.
// Assumes both port clocks are ordinary inputs sampled by mclk at no more than half its rate.
`timescale 1ns/1ps
module bidir_clocked_fifo_mailbox (
    // System clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Port A control.
    input wire logic port_a_clock,
    input wire logic port_a_chip_select,
    input wire logic port_a_master_gate,
    input wire logic a_direction,
    input wire logic port_a_mailbox_select,
    input wire logic a_parity_gen,
    // Port A data.
    input wire logic [35:0] a_data_in,
    output logic [35:0] a_data_out,
    output logic a_data_oe,
    // Port A status.
    output logic a_side_full_flag,
    output logic a_side_almost_full,
    output logic a_side_empty_flag,
    output logic a_side_almost_empty,
    output logic a_parity_error_n,
    // Port B control.
    input wire logic port_b_clock,
    input wire logic port_b_chip_select,
    input wire logic port_b_master_gate,
    input wire logic b_direction,
    input wire logic width_sel_0,
    input wire logic width_sel_1,
    input wire logic endian_lane_select,
    input wire logic swap_sel_0,
    input wire logic swap_sel_1,
    input wire logic b_parity_gen,
    // Port B data.
    input wire logic [35:0] b_data_in,
    output logic [35:0] b_data_out,
    output logic b_data_oe,
    // Port B status.
    output logic b_side_full_flag,
    output logic b_side_almost_full,
    output logic b_side_empty_flag,
    output logic b_side_almost_empty,
    output logic b_parity_error_n,
    // Shared configuration and mailbox flags.
    input wire logic offset_sel_0,
    input wire logic offset_sel_1,
    input wire logic parity_odd_sel,
    output logic mail_ab_flag,
    output logic mail_ba_flag
);

    logic a_clk_q;
    logic b_clk_q;
    logic [1:0] offset_code;
    logic offset_done;
    logic [35:0] mailbox_ab;
    logic [35:0] mailbox_ba;
    logic [35:0] a_out_q;
    logic [35:0] b_out_q;
    logic [35:0] b_hold;
    logic [35:0] b_asm;
    logic [1:0] b_idx;
    logic [35:0] head_ab;
    logic [35:0] head_ba;
    bidir_fifo_pkg::queue_flags_s flags_ab;
    bidir_fifo_pkg::queue_flags_s flags_ba;

    // Port clocks are sampled, so each rising edge becomes one mclk-wide tick.
    wire a_tick = port_a_clock & ~a_clk_q;
    wire b_tick = port_b_clock & ~b_clk_q;

    wire a_access = a_tick & ~port_a_chip_select & port_a_master_gate;
    wire a_wr = a_access & a_direction;
    wire a_rd = a_access & ~a_direction;
    wire a_mb_wr = a_wr & port_a_mailbox_select;
    wire a_mb_rd = a_rd & port_a_mailbox_select;
    wire a_q_wr = a_wr & ~port_a_mailbox_select;
    wire a_q_pop = a_rd & ~port_a_mailbox_select & flags_ba.empty;

    wire bidir_fifo_pkg::width_e b_width = bidir_fifo_pkg::width_e'({width_sel_1, width_sel_0});
    wire bidir_fifo_pkg::swap_e b_swap = bidir_fifo_pkg::swap_e'({swap_sel_1, swap_sel_0});
    wire b_mail = b_width == bidir_fifo_pkg::WIDTH_MAIL;
    wire b_access = b_tick & ~port_b_chip_select & port_b_master_gate;
    wire b_wr = b_access & b_direction;
    wire b_rd = b_access & ~b_direction;
    wire b_mb_wr = b_wr & b_mail;
    wire b_mb_rd = b_rd & b_mail;
    wire b_piece_wr = b_wr & ~b_mail & flags_ba.full;
    wire b_pop = b_rd & ~b_mail & (b_idx == 2'h0) & flags_ab.empty;
    wire b_piece_rd = b_rd & ~b_mail & ((b_idx != 2'h0) | flags_ab.empty);

    wire b_last = (b_width == bidir_fifo_pkg::WIDTH_LONG)
        | ((b_width == bidir_fifo_pkg::WIDTH_WORD) & (b_idx == 2'h1))
        | ((b_width == bidir_fifo_pkg::WIDTH_BYTE) & (b_idx == 2'h3));

    // Incoming piece from the selected lanes, assembled most significant piece first.
    wire [17:0] b_in_word = endian_lane_select ? b_data_in[17:0] : b_data_in[35:18];
    wire [8:0] b_in_byte = endian_lane_select ? b_data_in[8:0] : b_data_in[35:27];
    wire [35:0] b_next_asm = (b_width == bidir_fifo_pkg::WIDTH_WORD) ? {b_asm[17:0], b_in_word}
        : (b_width == bidir_fifo_pkg::WIDTH_BYTE) ? {b_asm[26:0], b_in_byte}
        : b_data_in;
    wire b_push = b_piece_wr & b_last;
    wire [35:0] b_push_data = bidir_fifo_pkg::swap_lanes(b_next_asm, b_swap);

    // Outgoing long word after swapping, and the piece to place on the lanes.
    wire [35:0] b_pop_word = bidir_fifo_pkg::swap_lanes(head_ab, b_swap);
    wire [35:0] b_src = b_pop ? b_pop_word : b_hold;
    wire [17:0] b_src_word = b_idx[0] ? b_src[17:0] : b_src[35:18];
    wire [8:0] b_src_byte = (b_idx == 2'h0) ? b_src[35:27] : (b_idx == 2'h1) ? b_src[26:18]
        : (b_idx == 2'h2) ? b_src[17:9] : b_src[8:0];
    wire [35:0] b_lanes_word = endian_lane_select ? {18'h0, b_src_word} : {b_src_word, 18'h0};
    wire [35:0] b_lanes_byte = endian_lane_select ? {27'h0, b_src_byte} : {b_src_byte, 27'h0};
    wire [35:0] b_place = (b_width == bidir_fifo_pkg::WIDTH_WORD) ? b_lanes_word
        : (b_width == bidir_fifo_pkg::WIDTH_BYTE) ? b_lanes_byte : b_src;

    // Lanes that carry valid data for checking on port B.
    wire [3:0] b_lane_mask = (b_width == bidir_fifo_pkg::WIDTH_WORD)
        ? (endian_lane_select ? 4'h3 : 4'hC)
        : (b_width == bidir_fifo_pkg::WIDTH_BYTE)
        ? (endian_lane_select ? 4'h1 : 4'h8) : 4'hF;
    wire [3:0] a_fail = bidir_fifo_pkg::parity_fail(a_data_in, parity_odd_sel);
    wire [3:0] b_fail = bidir_fifo_pkg::parity_fail(b_data_in, parity_odd_sel) & b_lane_mask;

    wire [6:0] offset = (offset_code == 2'h3) ? bidir_fifo_pkg::OFFSET_CODE_3
        : (offset_code == 2'h2) ? bidir_fifo_pkg::OFFSET_CODE_2
        : (offset_code == 2'h1) ? bidir_fifo_pkg::OFFSET_CODE_1
        : bidir_fifo_pkg::OFFSET_CODE_0;

    wire [35:0] a_raw = port_a_mailbox_select ? mailbox_ba : a_out_q;
    wire [35:0] b_raw = b_mail ? mailbox_ab : b_out_q;

    assign a_data_out = a_parity_gen ? bidir_fifo_pkg::fix_parity(a_raw, parity_odd_sel) : a_raw;
    assign b_data_out = b_parity_gen ? bidir_fifo_pkg::fix_parity(b_raw, parity_odd_sel) : b_raw;
    assign a_data_oe = ~port_a_chip_select & ~a_direction;
    assign b_data_oe = ~port_b_chip_select & ~b_direction;

    assign a_side_full_flag = flags_ab.full;
    assign a_side_almost_full = flags_ab.almost_full;
    assign a_side_empty_flag = flags_ba.empty;
    assign a_side_almost_empty = flags_ba.almost_empty;
    assign b_side_full_flag = flags_ba.full;
    assign b_side_almost_full = flags_ba.almost_full;
    assign b_side_empty_flag = flags_ab.empty;
    assign b_side_almost_empty = flags_ab.almost_empty;

    fifo_queue #(.DEPTH(bidir_fifo_pkg::QUEUE_DEPTH), .WIDTH(bidir_fifo_pkg::DATA_WIDTH),
        .PTR(bidir_fifo_pkg::PTR_WIDTH)) queue_ab (
        .mclk(mclk),
        .nrst(nrst),
        .wr_tick(a_tick),
        .wr_req(a_q_wr),
        .wr_data(a_data_in),
        .rd_tick(b_tick),
        .rd_req(b_pop),
        .head(head_ab),
        .offset(offset),
        .flags(flags_ab)
    );

    fifo_queue #(.DEPTH(bidir_fifo_pkg::QUEUE_DEPTH), .WIDTH(bidir_fifo_pkg::DATA_WIDTH),
        .PTR(bidir_fifo_pkg::PTR_WIDTH)) queue_ba (
        .mclk(mclk),
        .nrst(nrst),
        .wr_tick(b_tick),
        .wr_req(b_push),
        .wr_data(b_push_data),
        .rd_tick(a_tick),
        .rd_req(a_q_pop),
        .head(head_ba),
        .offset(offset),
        .flags(flags_ba)
    );

    // The strap is caught by the first clock after release, never by the reset itself.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            offset_done <= 1'b0;
            offset_code <= bidir_fifo_pkg::OFFSET_CODE_RESET;
        end
        else if (!offset_done)
        begin
            offset_done <= 1'b1;
            offset_code <= {offset_sel_1, offset_sel_0};
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            a_clk_q <= 1'b0;
            b_clk_q <= 1'b0;
            mail_ab_flag <= 1'b1;
            mail_ba_flag <= 1'b1;
            a_parity_error_n <= 1'b1;
            b_parity_error_n <= 1'b1;
            b_idx <= 2'h0;
        end
        else
        begin
            a_clk_q <= port_a_clock;
            b_clk_q <= port_b_clock;
            // New mail wins over a read that lands in the same cycle.
            if (a_mb_wr)
                mail_ab_flag <= 1'b0;
            else if (b_mb_rd)
                mail_ab_flag <= 1'b1;
            if (b_mb_wr)
                mail_ba_flag <= 1'b0;
            else if (a_mb_rd)
                mail_ba_flag <= 1'b1;
            a_parity_error_n <= ~|a_fail;
            b_parity_error_n <= ~|b_fail;
            if (b_piece_wr | b_piece_rd)
                b_idx <= b_last ? 2'h0 : b_idx + 2'h1;
        end
    end

    // Mailboxes start cleared so that their idle checks never meet unknown contents.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mailbox_ab <= 36'h0;
            mailbox_ba <= 36'h0;
        end
        else
        begin
            if (a_mb_wr)
                mailbox_ab <= a_data_in;
            if (b_mb_wr)
                mailbox_ba <= b_data_in;
        end
    end

    // Other data holding registers carry no reset; their contents are undefined until written.
    always_ff @(posedge mclk)
    begin
        if (a_q_pop)
            a_out_q <= head_ba;
        if (b_piece_wr)
            b_asm <= b_next_asm;
        if (b_pop)
            b_hold <= b_pop_word;
        if (b_piece_rd)
            b_out_q <= b_place;
    end

    a_oe_port_a: assert property (@(posedge mclk) disable iff (!nrst) port_a_chip_select |-> !a_data_oe)
        else $error("port A drives while deselected");
    a_oe_port_b: assert property (@(posedge mclk) disable iff (!nrst) port_b_chip_select |-> !b_data_oe)
        else $error("port B drives while deselected");
    a_mail_ab_write: assert property (@(posedge mclk) disable iff (!nrst) a_mb_wr |=> !mail_ab_flag)
        else $error("A to B mail flag not low after write");
    a_mail_ab_read: assert property (@(posedge mclk) disable iff (!nrst)
        (b_mb_rd && !a_mb_wr) |=> mail_ab_flag)
        else $error("A to B mail flag not high after read");
    a_mail_ba_write: assert property (@(posedge mclk) disable iff (!nrst) b_mb_wr |=> !mail_ba_flag)
        else $error("B to A mail flag not low after write");
    a_port_a_idle: assert property (@(posedge mclk) disable iff (!nrst)
        (port_a_chip_select || !port_a_master_gate) |=> $stable(mailbox_ab) && !$fell(mail_ab_flag))
        else $error("port A acted while not enabled");
    a_port_b_idle: assert property (@(posedge mclk) disable iff (!nrst)
        (port_b_chip_select || !port_b_master_gate) |=> $stable(mailbox_ba) && !$fell(mail_ba_flag))
        else $error("port B acted while not enabled");
    a_offset_held: assert property (@(posedge mclk) disable iff (!nrst)
        offset_done |=> $stable(offset_code))
        else $error("offset select changed after capture");
    a_mailbox_a_out: assert property (@(posedge mclk) disable iff (!nrst)
        (port_a_mailbox_select && !a_parity_gen) |-> a_data_out == mailbox_ba)
        else $error("port A not showing mailbox");

endmodule

// [common/bidir_fifo_pkg.sv]
// Shared constants, types and helper functions for the bidirectional queue and mailbox block.
// Assumes every consumer refers to items with the package scope and never imports it.
package bidir_fifo_pkg;

    localparam int DATA_WIDTH = 36;
    localparam int QUEUE_DEPTH = 64;
    localparam int PTR_WIDTH = 7;
    localparam int WORD_WIDTH = 18;
    localparam int BYTE_WIDTH = 9;
    localparam int LANE_COUNT = 4;

    // Almost-flag offsets for captured select codes 11, 10, 01 and 00.
    localparam logic [6:0] OFFSET_CODE_3 = 7'h10;
    localparam logic [6:0] OFFSET_CODE_2 = 7'h0C;
    localparam logic [6:0] OFFSET_CODE_1 = 7'h08;
    localparam logic [6:0] OFFSET_CODE_0 = 7'h04;
    localparam logic [1:0] OFFSET_CODE_RESET = 2'h0;

    typedef enum logic [1:0] {
        WIDTH_LONG = 2'b00,
        WIDTH_WORD = 2'b01,
        WIDTH_BYTE = 2'b10,
        WIDTH_MAIL = 2'b11
    } width_e;

    typedef enum logic [1:0] {
        SWAP_NONE = 2'b00,
        SWAP_BYTE = 2'b01,
        SWAP_WORD = 2'b10,
        SWAP_BYTE_WORD = 2'b11
    } swap_e;

    typedef struct packed {
        logic full;
        logic almost_full;
        logic empty;
        logic almost_empty;
    } queue_flags_s;

    // Reorders the four 9-bit lanes of a long word.
    function automatic logic [35:0] swap_lanes(input logic [35:0] w, input swap_e mode);
        logic [35:0] r;
        r = w;
        case (mode)
            SWAP_BYTE: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
            SWAP_WORD: r = {w[17:0], w[35:18]};
            SWAP_BYTE_WORD: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: r = w;
        endcase
        return r;
    endfunction

    // Rewrites the top bit of each lane so that the lane has the selected parity.
    function automatic logic [35:0] fix_parity(input logic [35:0] w, input logic odd);
        logic [35:0] r;
        r = w;
        for (int i = 0; i < LANE_COUNT; i++)
        begin
            r[BYTE_WIDTH*i+8] = (^w[BYTE_WIDTH*i +: 8]) ^ odd;
        end
        return r;
    endfunction

    // One bit per lane, set where the lane fails the selected parity.
    function automatic logic [3:0] parity_fail(input logic [35:0] w, input logic odd);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < LANE_COUNT; i++)
        begin
            r[i] = (^w[BYTE_WIDTH*i +: BYTE_WIDTH]) != odd;
        end
        return r;
    endfunction

endpackage

// [hw/fifo_queue.sv]
// One 64 by 36 queue with full, almost-full, empty and almost-empty flags.
// Assumes the writing and reading port edges arrive as one-cycle ticks in the mclk domain.
`timescale 1ns/1ps
module fifo_queue #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 36,
    parameter int PTR = 7
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Writing side.
    input wire logic wr_tick,
    input wire logic wr_req,
    input wire logic [WIDTH-1:0] wr_data,
    // Reading side.
    input wire logic rd_tick,
    input wire logic rd_req,
    output logic [WIDTH-1:0] head,
    // Flags and offset.
    input wire logic [PTR-1:0] offset,
    output bidir_fifo_pkg::queue_flags_s flags
);

    localparam logic [PTR-1:0] FULL_COUNT = PTR'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR-1:0] wptr;
    logic [PTR-1:0] rptr;
    logic full_s1;
    logic almost_full_s1;
    logic empty_s1;
    logic almost_empty_s1;

    wire do_wr = wr_tick & wr_req & flags.full;
    wire do_rd = rd_tick & rd_req & flags.empty;
    wire [PTR-1:0] count = wptr - rptr;
    wire [PTR-1:0] next_count = count + {{(PTR-1){1'b0}}, do_wr} - {{(PTR-1){1'b0}}, do_rd};
    wire not_full = next_count != FULL_COUNT;
    wire not_empty = next_count != {PTR{1'b0}};
    wire many_free = (FULL_COUNT - next_count) > offset;
    wire many_held = next_count > offset;
    wire fill_now = do_wr & ~not_full;
    wire drain_now = do_rd & ~not_empty;

    assign head = mem[rptr[PTR-2:0]];

    always_ff @(posedge mclk)
    begin
        if (do_wr)
        begin
            mem[wptr[PTR-2:0]] <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wptr <= {PTR{1'b0}};
            rptr <= {PTR{1'b0}};
        end
        else
        begin
            wptr <= wptr + {{(PTR-1){1'b0}}, do_wr};
            rptr <= rptr + {{(PTR-1){1'b0}}, do_rd};
        end
    end

    // A filling write or draining read drops its flag at once; the way back up takes two
    // edges of the port that owns the flag, so the flag never admits a bad access.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            {full_s1, flags.full} <= 2'b00;
            {empty_s1, flags.empty} <= 2'b00;
            {almost_full_s1, flags.almost_full} <= 2'b11;
            {almost_empty_s1, flags.almost_empty} <= 2'b00;
        end
        else
        begin
            if (fill_now)
                {full_s1, flags.full} <= 2'b00;
            else if (wr_tick)
                {full_s1, flags.full} <= {not_full, full_s1};
            if (drain_now)
                {empty_s1, flags.empty} <= 2'b00;
            else if (rd_tick)
                {empty_s1, flags.empty} <= {not_empty, empty_s1};
            if (wr_tick)
                {almost_full_s1, flags.almost_full} <= {many_free, almost_full_s1};
            if (rd_tick)
                {almost_empty_s1, flags.almost_empty} <= {many_held, almost_empty_s1};
        end
    end

    a_count_in_range: assert property (@(posedge mclk) disable iff (!nrst) count <= FULL_COUNT)
        else $error("queue count exceeds depth");
    a_full_blocks_write: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_tick && wr_req && !flags.full) |=> $stable(wptr))
        else $error("write pointer moved while full flag low");
    a_empty_rise_delay: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(flags.empty) |-> $past(empty_s1) && $past(rd_tick))
        else $error("empty flag rose without passing the first stage");

endmodule

// [test/port_clock_model.sv]
// Far-side clock source for one port of the queue block.
// Assumes mclk is the system clock; the port clock toggles on every rising mclk edge.
`timescale 1ns/1ps
module port_clock_model #(
    parameter logic INIT = 1'b0
) (
    // System side.
    input wire logic mclk,
    // Far side.
    output logic port_clock
);
    initial port_clock = INIT;
    // The port clock runs free, also through reset, so reset sees four of its rising edges.
    always @(posedge mclk)
        port_clock <= ~port_clock;
endmodule

// [test/tb_top.sv]
// Self-checking bench for the bidirectional queue and mailbox block.
// Assumes the port clocks come from the far-side models and reset is held 8 cycles.
`timescale 1ns/1ps
module tb_top;
    logic mclk, nrst, port_a_clock, port_b_clock;
    logic port_a_chip_select, port_a_master_gate, a_direction, port_a_mailbox_select;
    logic port_b_chip_select, port_b_master_gate, b_direction, width_sel_0, width_sel_1;
    logic a_parity_gen, b_parity_gen, endian_lane_select, swap_sel_0, swap_sel_1;
    logic offset_sel_0, offset_sel_1, parity_odd_sel;
    logic [35:0] a_data_in, b_data_in, a_data_out, b_data_out;
    logic a_data_oe, a_side_full_flag, a_side_almost_full, a_side_empty_flag;
    logic a_side_almost_empty, a_parity_error_n, b_data_oe, b_side_full_flag;
    logic b_side_almost_full, b_side_empty_flag, b_side_almost_empty, b_parity_error_n;
    logic mail_ab_flag, mail_ba_flag;
    logic [35:0] exp_swap [4] = '{{9'h103, 9'h102, 9'h101, 9'h100},
        {9'h100, 9'h101, 9'h102, 9'h103}, {9'h101, 9'h100, 9'h103, 9'h102},
        {9'h102, 9'h103, 9'h100, 9'h101}};
    int n_mismatch = 0;
    int n_tests = 0;

    bidir_clocked_fifo_mailbox dut_u (.*);
    port_clock_model #(.INIT(1'b0)) clk_a_u (.mclk(mclk), .port_clock(port_a_clock));
    port_clock_model #(.INIT(1'b1)) clk_b_u (.mclk(mclk), .port_clock(port_b_clock));

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Controls are set while the port clock is low, so the next rise takes them whole.
    task automatic acc(input logic b, input logic wr, input logic mb, input logic g,
                       input logic [35:0] d);
        do @(posedge mclk); while ((b ? port_b_clock : port_a_clock) !== 1'b0);
        if (b)
        begin
            port_b_chip_select <= 1'b0;
            port_b_master_gate <= g;
            b_direction <= wr;
            {width_sel_1, width_sel_0} <= {mb, mb};
            b_data_in <= d;
        end
        else
        begin
            port_a_chip_select <= 1'b0;
            port_a_master_gate <= g;
            a_direction <= wr;
            port_a_mailbox_select <= mb;
            a_data_in <= d;
        end
        repeat (2) @(posedge mclk);
        {port_a_chip_select, port_b_chip_select} <= 2'h3;
        {port_a_master_gate, port_b_master_gate} <= 2'h0;
        a_data_in <= ~a_data_in;
        b_data_in <= ~b_data_in;
        #1;
    endtask

    task automatic t_reset();
        repeat (6) @(posedge mclk);
        #1 chk({a_side_full_flag, a_side_almost_full, a_side_empty_flag, a_side_almost_empty,
            b_side_full_flag, b_side_almost_full, b_side_empty_flag, b_side_almost_empty,
            mail_ab_flag, mail_ba_flag}, 36'h113);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (12) @(posedge mclk);
        #1 chk({a_side_full_flag, b_side_full_flag, a_side_almost_full, b_side_almost_full},
            36'hF);
    endtask

    task automatic t_fill();
        acc(1'b0, 1'b1, 1'b0, 1'b0, 36'hA);
        repeat (12) @(posedge mclk);
        chk(b_side_empty_flag, 1'b0);
        for (int i = 1; i <= 5; i++)
        begin
            acc(1'b0, 1'b1, 1'b0, 1'b1, 36'h1_2345_6780 + 36'(i));
            repeat (12) @(posedge mclk);
            chk(b_side_almost_empty, i > 4);
        end
        chk(b_side_empty_flag, 1'b1);
        // The sixth read meets an empty queue and must leave the output alone.
        for (int i = 1; i <= 6; i++)
        begin
            acc(1'b1, 1'b0, 1'b0, 1'b1, 36'h0);
            chk(b_data_out, 36'h1_2345_6780 + 36'(i > 5 ? 5 : i));
            chk(b_data_oe, 1'b0);
            repeat (12) @(posedge mclk);
        end
        chk(b_side_empty_flag, 1'b0);
    endtask

    task automatic t_back();
        for (int m = 0; m < 4; m++)
        begin
            @(posedge mclk);
            {swap_sel_1, swap_sel_0} <= 2'(m);
            acc(1'b1, 1'b1, 1'b0, 1'b1, {9'h103, 9'h102, 9'h101, 9'h100});
            repeat (12) @(posedge mclk);
            chk(a_side_empty_flag, 1'b1);
            acc(1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
            chk(a_data_out, exp_swap[m]);
        end
    endtask

    task automatic t_mail();
        acc(1'b0, 1'b1, 1'b1, 1'b1, 36'hC_AFE0_0001);
        chk(mail_ab_flag, 1'b0);
        acc(1'b1, 1'b0, 1'b1, 1'b1, 36'h0);
        chk(b_data_out, 36'hC_AFE0_0001);
        chk(mail_ab_flag, 1'b1);
        acc(1'b1, 1'b1, 1'b1, 1'b1, 36'h5_0000_000F);
        chk(mail_ba_flag, 1'b0);
        acc(1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
        chk(a_data_out, 36'h5_0000_000F);
        chk(mail_ba_flag, 1'b1);
        @(posedge mclk);
        a_parity_gen <= 1'b1;
        parity_odd_sel <= 1'b1;
        @(posedge mclk);
        #1 chk(a_data_out, 36'hD_0402_010F);
        chk(b_data_out, 36'hC_AFE0_0001);
    endtask

    // Two word pieces on the upper lanes make one long word, most significant piece first.
    task automatic t_width();
        @(posedge mclk);
        {swap_sel_1, swap_sel_0} <= 2'h0;
        a_parity_gen <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            do @(posedge mclk); while (port_b_clock !== 1'b0);
            {port_b_chip_select, port_b_master_gate, b_direction} <= 3'b011;
            {width_sel_1, width_sel_0} <= 2'h1;
            b_data_in <= (k == 0) ? {18'h24680, 18'h0} : {18'h13579, 18'h0};
            repeat (2) @(posedge mclk);
            port_b_chip_select <= 1'b1;
            port_b_master_gate <= 1'b0;
        end
        repeat (12) @(posedge mclk);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
        chk(a_data_out, 36'h9_1A01_3579);
        @(posedge mclk);
        a_data_in <= 36'h0;
        b_data_in <= 36'h0;
        parity_odd_sel <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({a_parity_error_n, b_parity_error_n}, 36'h0);
        @(posedge mclk);
        parity_odd_sel <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({a_parity_error_n, b_parity_error_n}, 36'h3);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        nrst = 1'b0;
        {port_a_chip_select, port_b_chip_select} = 2'h3;
        {port_a_master_gate, port_b_master_gate, a_direction, b_direction} = 4'h0;
        {port_a_mailbox_select, width_sel_0, width_sel_1, endian_lane_select} = 4'h0;
        {swap_sel_0, swap_sel_1, a_parity_gen, b_parity_gen} = 4'h0;
        {offset_sel_0, offset_sel_1, parity_odd_sel} = 3'h0;
        a_data_in = 36'h0;
        b_data_in = 36'h0;
        t_reset();
        t_fill();
        t_back();
        t_mail();
        t_width();
        results();
    end

    // A run needs well under a thousand cycles; this limit only cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        results();
    end
endmodule
